// ### hfr_pkg.sv
`default_nettype none
package hfr_pkg;
    // Clock and host serial timing
    localparam int CLK_HZ = 10_000_000;
    localparam int BAUD_RATE = 115200;
    localparam int BIT_CYCLES = CLK_HZ / BAUD_RATE;
    localparam int BAUD_W = 8;
    localparam logic [7:0] BIT_LAST = 8'(BIT_CYCLES - 1);
    localparam logic [7:0] BIT_HALF = 8'(BIT_CYCLES / 2 - 1);
    localparam logic [3:0] UART_STOP_BIT = 4'h9;

    // Receive window timing
    localparam int WINDOW_MS = 22;
    localparam int WINDOW_CYCLES = WINDOW_MS * (CLK_HZ / 1000);
    localparam int TMR_W = 18;

    // Receive buffer fill levels
    localparam int CNT_W = 7;
    localparam logic [6:0] BUF_DEPTH = 7'h40;
    localparam logic [6:0] CTS_HOLD_LEVEL = 7'h3c;
    localparam logic [6:0] CNT_ZERO = 7'h00;
    localparam logic [6:0] CNT_ONE = 7'h01;

    // Quiet line time that ends a response frame
    localparam int RESP_IDLE_BITS = 20;
    localparam int RESP_IDLE_CYCLES = RESP_IDLE_BITS * BIT_CYCLES;
    localparam int IDLE_W = 11;
    localparam logic [10:0] RESP_IDLE_LAST = 11'(RESP_IDLE_CYCLES - 1);

    // Frame check sequence
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'h1021;

    // Pin synchroniser lanes
    localparam int LANE_UART = 0;
    localparam int LANE_IR = 1;

    typedef enum logic [2:0] {
        ST_START = 3'h0,
        ST_WINDOW = 3'h1,
        ST_CRC = 3'h2,
        ST_SEND = 3'h3,
        ST_RESP = 3'h4
    } hfr_state_type;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } hfr_rx_byte_type;
endpackage
`default_nettype wire

// ### hfr_framer.sv
`default_nettype none
module hfr_framer #(
    parameter int WINDOW_CYCLES = hfr_pkg::WINDOW_CYCLES
) (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic UART_RX,
    input wire logic INFRARED_RX_IN,
    output logic CLEAR_TO_SEND_N,
    output logic INFRARED_TX_OUT
);
    localparam logic [17:0] TMR_LAST = 18'(WINDOW_CYCLES - 1);

    // Pin synchronisers and filtered levels
    logic [1:0] s1_reg, s2_reg, s3_reg, lvl_reg, lvl_next;
    // Host serial receiver
    logic r_busy_reg, r_busy_next;
    logic [7:0] r_baud_reg, r_baud_next;
    logic [3:0] r_bit_reg, r_bit_next;
    logic [7:0] r_sh_reg, r_sh_next;
    hfr_pkg::hfr_rx_byte_type rxb_reg, rxb_next;
    // Window, frame and response control
    hfr_pkg::hfr_state_type state_reg, state_next;
    logic cts_reg, cts_next;
    logic irtx_reg, irtx_next;
    logic [17:0] tmr_reg, tmr_next;
    logic [6:0] count_reg, count_next;
    logic [6:0] idx_reg, idx_next;
    logic [15:0] crc_reg, crc_next;
    logic [9:0] tx_sh_reg, tx_sh_next;
    logic [3:0] tx_bit_reg, tx_bit_next;
    logic [7:0] tx_baud_reg, tx_baud_next;
    logic seen_reg, seen_next;
    logic [10:0] idle_reg, idle_next;
    logic wr_en;
    logic [7:0] buf_mem [0:63];

    // One byte folded into the running CRC, msb first
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ((r << 1) ^ hfr_pkg::CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    // Serial word for frame position: payload, then CRC high, then CRC low
    function automatic logic [9:0] frame_word(input logic [6:0] i, input logic [6:0] n,
                                             input logic [15:0] c);
        logic [7:0] b;
        b = (i < n) ? buf_mem[i[5:0]] : ((i == n) ? c[15:8] : c[7:0]);
        return {1'b1, b, 1'b0};
    endfunction

    // Level accepted only once the second and third stages agree
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            lvl_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : lvl_reg[i];
        end
    end

    // Host receiver runs regardless of clear-to-send, so late bytes land
    always_comb begin
        r_busy_next = r_busy_reg;
        r_baud_next = r_baud_reg;
        r_bit_next = r_bit_reg;
        r_sh_next = r_sh_reg;
        rxb_next = '{valid: 1'b0, data: r_sh_reg};
        if (!r_busy_reg) begin
            if (!lvl_reg[hfr_pkg::LANE_UART]) begin
                r_busy_next = 1'b1;
                r_baud_next = hfr_pkg::BIT_HALF;
                r_bit_next = 4'h0;
            end
        end else if (r_baud_reg != 8'h00) begin
            r_baud_next = r_baud_reg - 8'h01;
        end else begin
            r_baud_next = hfr_pkg::BIT_LAST;
            r_bit_next = r_bit_reg + 4'h1;
            if (r_bit_reg == 4'h0 && lvl_reg[hfr_pkg::LANE_UART]) begin
                r_busy_next = 1'b0; // Glitch, not a start bit
            end else if (r_bit_reg == hfr_pkg::UART_STOP_BIT) begin
                r_busy_next = 1'b0;
                rxb_next.valid = lvl_reg[hfr_pkg::LANE_UART];
            end else if (r_bit_reg != 4'h0) begin
                r_sh_next = {lvl_reg[hfr_pkg::LANE_UART], r_sh_reg[7:1]};
            end
        end
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            s1_reg <= 2'h3;
            s2_reg <= 2'h3;
            s3_reg <= 2'h3;
            lvl_reg <= 2'h3;
            r_busy_reg <= 1'b0;
            r_baud_reg <= 8'h00;
            r_bit_reg <= 4'h0;
            r_sh_reg <= 8'h00;
            rxb_reg <= '0;
        end else begin
            s1_reg <= {INFRARED_RX_IN, UART_RX};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            lvl_reg <= lvl_next;
            r_busy_reg <= r_busy_next;
            r_baud_reg <= r_baud_next;
            r_bit_reg <= r_bit_next;
            r_sh_reg <= r_sh_next;
            rxb_reg <= rxb_next;
        end
    end

    // Window, processing, transmit and response sequencing
    always_comb begin
        state_next = state_reg;
        cts_next = cts_reg;
        tmr_next = tmr_reg;
        count_next = count_reg;
        idx_next = idx_reg;
        crc_next = crc_reg;
        tx_sh_next = tx_sh_reg;
        tx_bit_next = tx_bit_reg;
        tx_baud_next = tx_baud_reg;
        seen_next = seen_reg;
        idle_next = idle_reg;
        wr_en = 1'b0;
        case (state_reg)
            hfr_pkg::ST_START: begin
                cts_next = 1'b0;
                tmr_next = '0;
                state_next = hfr_pkg::ST_WINDOW;
            end
            hfr_pkg::ST_WINDOW: begin
                tmr_next = tmr_reg + 18'h00001;
                // Bytes past the 64th cannot arrive: the window is shut by then
                wr_en = rxb_reg.valid && count_reg < hfr_pkg::BUF_DEPTH;
                if (wr_en) begin
                    count_next = count_reg + hfr_pkg::CNT_ONE;
                end
                if (count_next >= hfr_pkg::CTS_HOLD_LEVEL) begin
                    cts_next = 1'b1;
                end
                if (count_next == hfr_pkg::BUF_DEPTH) begin
                    cts_next = 1'b1;
                    state_next = hfr_pkg::ST_CRC;
                end else if (tmr_reg == TMR_LAST) begin
                    cts_next = 1'b1;
                    // Empty window just reopens; nothing to frame
                    state_next = (count_next == hfr_pkg::CNT_ZERO) ? hfr_pkg::ST_START
                        : hfr_pkg::ST_CRC;
                end
                idx_next = '0;
                crc_next = hfr_pkg::CRC_INIT;
            end
            hfr_pkg::ST_CRC: begin
                // One byte per clock; 64 bytes cost only 6.4 us
                if (idx_reg == count_reg) begin
                    state_next = hfr_pkg::ST_SEND;
                    idx_next = '0;
                    tx_sh_next = frame_word(7'h00, count_reg, crc_reg);
                    tx_bit_next = 4'h0;
                    tx_baud_next = hfr_pkg::BIT_LAST;
                end else begin
                    crc_next = crc_byte(crc_reg, buf_mem[idx_reg[5:0]]);
                    idx_next = idx_reg + hfr_pkg::CNT_ONE;
                end
            end
            hfr_pkg::ST_SEND: begin
                if (tx_baud_reg != 8'h00) begin
                    tx_baud_next = tx_baud_reg - 8'h01;
                end else if (tx_bit_reg != hfr_pkg::UART_STOP_BIT) begin
                    tx_baud_next = hfr_pkg::BIT_LAST;
                    tx_bit_next = tx_bit_reg + 4'h1;
                    tx_sh_next = {1'b1, tx_sh_reg[9:1]};
                end else if (idx_reg == count_reg + hfr_pkg::CNT_ONE) begin
                    state_next = hfr_pkg::ST_RESP;
                    seen_next = 1'b0;
                    idle_next = '0;
                end else begin
                    idx_next = idx_reg + hfr_pkg::CNT_ONE;
                    tx_sh_next = frame_word(idx_reg + hfr_pkg::CNT_ONE, count_reg, crc_reg);
                    tx_bit_next = 4'h0;
                    tx_baud_next = hfr_pkg::BIT_LAST;
                end
            end
            hfr_pkg::ST_RESP: begin
                // No timeout: a silent primary device holds the block here
                if (!lvl_reg[hfr_pkg::LANE_IR]) begin
                    seen_next = 1'b1;
                    idle_next = '0;
                end else if (seen_reg) begin
                    idle_next = idle_reg + 11'h001;
                    if (idle_reg == hfr_pkg::RESP_IDLE_LAST) begin
                        count_next = hfr_pkg::CNT_ZERO;
                        state_next = hfr_pkg::ST_START;
                    end
                end
            end
            default: begin
                state_next = hfr_pkg::ST_START;
            end
        endcase
        irtx_next = (state_next == hfr_pkg::ST_SEND) ? tx_sh_next[0] : 1'b1;
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_reg <= hfr_pkg::ST_START;
            cts_reg <= 1'b1;
            irtx_reg <= 1'b1;
            tmr_reg <= '0;
            count_reg <= '0;
            idx_reg <= '0;
            crc_reg <= hfr_pkg::CRC_INIT;
            tx_sh_reg <= 10'h3ff;
            tx_bit_reg <= 4'h0;
            tx_baud_reg <= 8'h00;
            seen_reg <= 1'b0;
            idle_reg <= '0;
        end else begin
            state_reg <= state_next;
            cts_reg <= cts_next;
            irtx_reg <= irtx_next;
            tmr_reg <= tmr_next;
            count_reg <= count_next;
            idx_reg <= idx_next;
            crc_reg <= crc_next;
            tx_sh_reg <= tx_sh_next;
            tx_bit_reg <= tx_bit_next;
            tx_baud_reg <= tx_baud_next;
            seen_reg <= seen_next;
            idle_reg <= idle_next;
        end
    end

    // Buffer array has no reset; contents are only read below count_reg
    always_ff @(posedge CLOCK) begin
        if (wr_en) begin
            buf_mem[count_reg[5:0]] <= rxb_reg.data;
        end
    end

    assign CLEAR_TO_SEND_N = cts_reg;
    assign INFRARED_TX_OUT = irtx_reg;

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);

    timer_start_a: assert property ($fell(cts_reg)
        |-> tmr_reg == '0 && state_reg == hfr_pkg::ST_WINDOW)
        else $error("window timer not restarted at clear-to-send fall");
    cts_hold_a: assert property (state_reg == hfr_pkg::ST_WINDOW
        && count_reg >= hfr_pkg::CTS_HOLD_LEVEL |-> cts_reg)
        else $error("clear-to-send low with 60 or more bytes buffered");
    full_close_a: assert property (state_reg == hfr_pkg::ST_WINDOW && wr_en
        && count_reg == hfr_pkg::BUF_DEPTH - hfr_pkg::CNT_ONE
        |=> state_reg == hfr_pkg::ST_CRC && cts_reg)
        else $error("64th byte did not close the window");
    timer_close_a: assert property (state_reg == hfr_pkg::ST_WINDOW && tmr_reg == TMR_LAST
        |=> state_reg != hfr_pkg::ST_WINDOW && cts_reg)
        else $error("window stayed open after timer expiry");
    early_close_a: assert property (state_reg == hfr_pkg::ST_WINDOW
        && $past(state_reg) == hfr_pkg::ST_WINDOW
        |-> tmr_reg == $past(tmr_reg) + 18'h00001 && count_reg < hfr_pkg::BUF_DEPTH)
        else $error("window closed or timer stalled too early");
    crc_run_a: assert property (state_reg == hfr_pkg::ST_CRC && idx_reg != count_reg
        |=> state_reg == hfr_pkg::ST_CRC && idx_reg == $past(idx_reg) + hfr_pkg::CNT_ONE)
        else $error("CRC pass skipped a byte");
    resp_wait_a: assert property (state_reg == hfr_pkg::ST_SEND
        ##1 state_reg != hfr_pkg::ST_SEND |-> state_reg == hfr_pkg::ST_RESP && irtx_reg)
        else $error("frame end not followed by response wait");
    byte_keep_a: assert property (state_reg == hfr_pkg::ST_WINDOW && rxb_reg.valid
        && count_reg < hfr_pkg::BUF_DEPTH |=> count_reg == $past(count_reg) + hfr_pkg::CNT_ONE)
        else $error("received byte not stored during window");
    reopen_a: assert property (state_reg == hfr_pkg::ST_RESP
        ##1 state_reg == hfr_pkg::ST_START |-> count_reg == hfr_pkg::CNT_ZERO ##1 !cts_reg)
        else $error("buffer not emptied or clear-to-send not lowered");

    full_window_c: cover property (state_reg == hfr_pkg::ST_WINDOW
        ##1 state_reg == hfr_pkg::ST_CRC && count_reg == hfr_pkg::BUF_DEPTH);
    timeout_window_c: cover property (state_reg == hfr_pkg::ST_WINDOW && tmr_reg == TMR_LAST
        && count_reg != hfr_pkg::CNT_ZERO);
    response_c: cover property (state_reg == hfr_pkg::ST_RESP
        ##1 state_reg == hfr_pkg::ST_START);
endmodule
`default_nettype wire

// ### hfr_host_model.sv
`default_nettype none
// Host controller on the serial side: 8N1 bytes, LSB first, idle high
module hfr_host_model (
    input wire logic clock,
    input wire logic cts_n,
    output var logic uart_rx
);
    timeunit 1ns;
    timeprecision 1ns;
    int sent_count;

    initial begin
        uart_rx = 1'b1;
        sent_count = 0;
    end

    // New window, new byte budget
    always @(negedge cts_n) begin
        sent_count = 0;
    end

    // Caller sits at a falling edge; gap lets the host answer slowly
    task automatic send_byte(input logic [7:0] value, input int gap);
        logic [9:0] frame;
        frame = {1'b1, value, 1'b0};
        if (sent_count < 64) begin
            sent_count++;
            for (int b = 0; b < 10; b++) begin
                uart_rx = frame[b];
                repeat (hfr_pkg::BIT_CYCLES) @(negedge clock);
            end
        end
        repeat (gap) @(negedge clock);
    endtask

    // Short low pulse on an idle line; the receiver must reject it as noise
    task automatic send_glitch(input int width);
        uart_rx = 1'b0;
        repeat (width) @(negedge clock);
        uart_rx = 1'b1;
    endtask
endmodule
`default_nettype wire

// ### host_uart_rx_window_framer_bench.sv
`default_nettype none
module host_uart_rx_window_framer_bench;
    timeunit 1ns;
    timeprecision 1ns;
    // Must exceed 64 back-to-back byte times, so the run is long
    localparam int WIN = 56000;
    localparam int BITC = hfr_pkg::BIT_CYCLES;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic ir_rx_in = 1'b1;
    wire logic uart_line;
    logic cts_n;
    logic ir_tx;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;

    // Clock and cycle count
    always #50 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;

    hfr_framer #(.WINDOW_CYCLES(WIN)) DUT (
        .CLOCK(clock),
        .SYS_RST(sys_rst),
        .UART_RX(uart_line),
        .INFRARED_RX_IN(ir_rx_in),
        .CLEAR_TO_SEND_N(cts_n),
        .INFRARED_TX_OUT(ir_tx)
    );

    hfr_host_model host (.clock(clock), .cts_n(cts_n), .uart_rx(uart_line));

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t ns: %s, got %h", $time, what, got);
        end
    endtask

    // Own model of the frame check, msb first
    function automatic logic [15:0] crc_next(input logic [15:0] c, input logic [7:0] d);
        logic fb;
        for (int i = 7; i >= 0; i--) begin
            fb = c[15] ^ d[i];
            c = {c[14:0], 1'b0} ^ (fb ? hfr_pkg::CRC_POLY : 16'h0000);
        end
        return c;
    endfunction

    task automatic wait_cts_low(input int limit, output int t);
        int n;
        n = 0;
        while (cts_n !== 1'b0 && n < limit) begin
            @(negedge clock);
            n++;
        end
        check(16'(cts_n), 16'h0000, "window did not open");
        t = cyc;
    endtask

    task automatic wait_tx_low(input int limit, output int t);
        int n;
        n = 0;
        while (ir_tx !== 1'b0 && n < limit) begin
            @(negedge clock);
            n++;
        end
        check(16'(ir_tx), 16'h0000, "no start bit on frame line");
        t = cyc;
    endtask

    // Words follow with no gap; sample mid-bit
    task automatic get_word(output logic [7:0] w);
        int t;
        wait_tx_low(200, t);
        repeat (BITC / 2) @(negedge clock);
        for (int i = 0; i < 8; i++) begin
            repeat (BITC) @(negedge clock);
            w[i] = ir_tx;
        end
        repeat (BITC) @(negedge clock);
        check(16'(ir_tx), 16'h0001, "stop bit");
    endtask

    task automatic test_full_window;
        int t0;
        int t1;
        wait_cts_low(100, t0);
        for (int i = 1; i <= 63; i++) begin
            host.send_byte(8'(i), 0);
            check(16'(cts_n), 16'(i >= 60), "clear-to-send level");
        end
        check(16'(ir_tx), 16'h0001, "frame before 64th byte");
        host.send_byte(8'h40, 0);
        wait_tx_low(300, t1);
        check(16'(t1 - t0 < WIN), 16'h0001, "window waited for timer");
        // Cut the long frame short with a mid-run reset
        sys_rst = 1'b1;
        repeat (5) @(negedge clock);
        check(16'({cts_n, ir_tx}), 16'h0003, "outputs during reset");
        sys_rst = 1'b0;
        $display("test_full_window done");
    endtask

    task automatic test_timer_window;
        logic [7:0] data [3];
        logic [15:0] crc;
        logic [7:0] w;
        int t0;
        int t1;
        data = '{8'ha5, 8'h3c, 8'h0f};
        crc = hfr_pkg::CRC_INIT;
        wait_cts_low(100, t0);
        // A short low pulse must not add a byte to the frame
        host.send_glitch(20);
        repeat (100) @(negedge clock);
        for (int i = 0; i < 3; i++) begin
            host.send_byte(data[i], 40);
            crc = crc_next(crc, data[i]);
        end
        wait_tx_low(WIN + 200, t1);
        check(16'(t1 - t0 >= WIN && t1 - t0 <= WIN + 20), 16'h0001, "window length");
        for (int i = 0; i < 3; i++) begin
            get_word(w);
            check(16'(w), 16'(data[i]), "payload byte");
        end
        get_word(w);
        check(16'(w), 16'(crc[15:8]), "check high byte");
        get_word(w);
        check(16'(w), 16'(crc[7:0]), "check low byte");
        // Primary device answers late; block must keep waiting
        repeat (1000) @(negedge clock);
        check(16'({cts_n, ir_tx}), 16'h0003, "left response wait early");
        ir_rx_in = 1'b0;
        repeat (BITC) @(negedge clock);
        ir_rx_in = 1'b1;
        t1 = cyc;
        wait_cts_low(1900, t0);
        check(16'(t0 - t1 >= hfr_pkg::RESP_IDLE_CYCLES), 16'h0001, "reopened too soon");
        check(16'(t0 - t1 <= hfr_pkg::RESP_IDLE_CYCLES + 20), 16'h0001, "reopened too late");
        $display("test_timer_window done");
    endtask

    task automatic print_verdict;
        $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (5) @(negedge clock);
        sys_rst = 1'b0;
        test_full_window;
        test_timer_window;
        print_verdict;
    end

    // Both tests need about 118000 cycles
    initial begin
        repeat (140000) @(posedge clock);
        bad_count++;
        $display("unexpected at %0t ns: watchdog expired", $time);
        print_verdict;
    end
endmodule
`default_nettype wire
